// *** hdl/crd_pkg.sv ***
// package for the card reader dma channel: function codes, field positions, status bits, types
// assumes a big-endian bit numbering convention on the system bus (bit 0 is the msb)
package crd_pkg;

  // function codes
  localparam logic [5:0] FC_OUT_INT_CTL = 6'h03;
  localparam logic [5:0] FC_OUT_CONTROL = 6'h01;
  localparam logic [5:0] FC_OUT_ADDRESS = 6'h09;
  localparam logic [5:0] FC_OUT_RANGE   = 6'h0D;
  localparam logic [5:0] FC_OUT_FORMAT  = 6'h11;
  localparam logic [5:0] FC_IN_INT_CTL  = 6'h02;
  localparam logic [5:0] FC_IN_BYTE_ADR = 6'h08;
  localparam logic [5:0] FC_IN_MOD_ADR  = 6'h0A;
  localparam logic [5:0] FC_IN_RANGE    = 6'h0C;
  localparam logic [5:0] FC_IN_FORMAT   = 6'h10;
  localparam logic [5:0] FC_IN_STATUS   = 6'h18;
  localparam logic [5:0] FC_IN_DEV_ID   = 6'h26;

  // control word bits, bus numbering (bit 0 = msb => vector index 15)
  localparam int CTL_INIT   = 15;
  localparam int CTL_STOP   = 14;
  localparam int CTL_TEST   = 13;
  localparam int CTL_HOLD   = 12;

  // status word vector indices (bus bit n => index 15-n)
  localparam int ST_READY   = 15;
  localparam int ST_ATTN    = 14;
  localparam int ST_DSR_ERR = 13;
  localparam int ST_MARK    = 12;
  localparam int ST_COL40   = 11;
  localparam int ST_COL51   = 10;
  localparam int ST_EXT_CLK = 9;
  localparam int ST_RD_CHK  = 8;
  localparam int ST_ASC_ERR = 7;
  localparam int ST_NXR     = 2;
  localparam int ST_PARITY  = 1;

  // reset values, binary format code and ascii error byte
  localparam logic [15:0] INT_TARGET_RST = 16'h0000;
  localparam logic [23:0] ADDR_RST       = 24'h00_0000;
  localparam logic [15:0] RANGE_RST      = 16'h0000;
  localparam logic [15:0] FORMAT_RST     = 16'h0000;
  localparam logic [15:0] FMT_BINARY     = 16'h0001;
  localparam logic [7:0]  ASCII_ERR_BYTE = 8'hFF;

  // card column from the reader side
  typedef struct packed {
    logic [11:0] holes;
    logic [7:0]  ascii;
    logic        ascii_ok;
    logic        last;
  } crd_column_s;

  // memory write toward the system bus
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] data;
    logic [1:0]  byte_en;
  } crd_mem_wr_s;

  typedef enum logic [1:0] { CRD_IDLE, CRD_READ, CRD_DRAIN } crd_state_e;

endpackage : crd_pkg

// *** hdl/crd_fifo.sv ***
// parametric fifo with valid/ready on both ends
// assumes single clock, synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module crd_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic                  empty
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q, rd_q;
  logic [AW:0]      cnt_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign empty     = !out_valid;
  assign out_data  = mem[rd_q];

  always_ff @(posedge clk) begin
    if (push) mem[wr_q] <= in_data;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      if (pop)  rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : crd_fifo
`default_nettype wire

// *** hdl/crd_channel.sv ***
// card reader dma channel: command decode, registers, column packing, dma writes
// assumes the bus interface presents one command per io_cmd_valid pulse and takes memory writes on mem_ready
//
// Overview of operation
// (R1) ascii byte bits 8..1 go to bus bits 0..7 left, 8..15 right
// (R2) decode output codes 03,01,09,0D,11 and input codes 02,08,0A,0C,10,18,26
// (R3) interrupt control word: bits 0-9 channel number, bits 10-15 level
// (R4) on interrupt drive channel number on address bus, level on data bus
// (R5) control command accepted even when busy; never refused
// (R6) initialize clears busy, blocks interrupts, selects ascii, starts self-test
// (R7) stop clears busy, ends transfer, interrupts if enabled, updates status
// (R8) hold address keeps dma address fixed for every column
// (R9) address arrives under code 09, range under code 0D
// (R10) 24-bit address is the starting byte address of the record
// (R11) host gives range positive, 1 to 2^15-1
// (R12) stop at range exhausted or end of card, whichever first
// (R13) range transfer starts card read and sets busy
// (R14) configuration 0 selects ascii, 1 selects binary
// (R15) input interrupt control returns the interrupt control register
// (R16) byte address input returns dma address bits 8-23
// (R17) module address input returns address bits 0-7 in data bits 8-15
// (R18) range input returns the range register
// (R19) configuration input returns the configuration register
// (R20) status input returns ready bit 0, attention bit 1, condition bits
// (R21) identifier input returns a fixed device identifier
// (R22) attention set on ready change, cleared by status read
// (R23) data service error set on lost data, cleared by next address load
// (R24) untranslatable column in ascii mode sets ascii error, byte forced ones
// (R25) binary mode: 12 bits right justified per word, upper four zero
// (R26) end of transfer clears busy and interrupts unless blocked
`timescale 1ns/10ps
`default_nettype none
module crd_channel
  import crd_pkg::*;
#(
  parameter logic [15:0] DEVICE_IDENTIFIER = 16'h0ABC, // arbitrary identifier value
  parameter int          FIFO_DEPTH = 32
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        io_cmd_valid,
  input  wire logic [5:0]  io_func,
  input  wire logic [23:0] io_wdata,
  output logic             io_ack,
  output logic             io_wait,
  output logic [15:0]      io_rdata,
  input  wire logic        col_valid,
  input  wire crd_column_s col_in,
  input  wire logic        dev_ready,
  input  wire logic [3:0]  dev_switches,
  input  wire logic        dev_read_check,
  input  wire logic        bus_parity_err,
  input  wire logic        mem_nak,
  output logic             mem_valid,
  output crd_mem_wr_s      mem_wr,
  input  wire logic        mem_ready,
  output logic             int_req,
  output logic [9:0]       int_addr,
  output logic [5:0]       int_data,
  input  wire logic        int_taken,
  output logic             busy,
  output logic             self_test
);
  logic [15:0] int_target_q;
  logic [23:0] addr_q;
  logic [23:0] wr_addr_q;
  logic [15:0] range_q;
  logic [15:0] remain_q;
  logic [15:0] format_q;
  logic        hold_q;
  logic        int_block_q;
  logic        int_pend_q;
  logic        test_q;
  logic        attn_q;
  logic        dsr_q;
  logic        rdchk_q;
  logic        ascerr_q;
  logic        nxr_q;
  logic        par_q;
  logic        ready_s1_q;
  logic        ready_s2_q;
  logic        ready_prev_q;
  logic [7:0]  hi_byte_q;
  logic        have_hi_q;
  crd_state_e  state_q;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // command decode
  function automatic logic is_cmd(input logic [5:0] f, input logic [5:0] c);
    return io_cmd_valid && (f == c);
  endfunction
  wire cmd_int   = is_cmd(io_func, FC_OUT_INT_CTL); // R2
  wire cmd_ctl   = is_cmd(io_func, FC_OUT_CONTROL);
  wire cmd_adr   = is_cmd(io_func, FC_OUT_ADDRESS);
  wire cmd_rng   = is_cmd(io_func, FC_OUT_RANGE); // R9
  wire cmd_fmt   = is_cmd(io_func, FC_OUT_FORMAT);
  wire cmd_stat  = is_cmd(io_func, FC_IN_STATUS);
  wire ctl_init  = cmd_ctl && io_wdata[CTL_INIT]; // R6
  wire ctl_stop  = cmd_ctl && io_wdata[CTL_STOP]; // R7
  wire known_cmd = cmd_int | cmd_ctl | cmd_adr | cmd_rng | cmd_fmt | cmd_stat
                 | is_cmd(io_func, FC_IN_INT_CTL) | is_cmd(io_func, FC_IN_BYTE_ADR)
                 | is_cmd(io_func, FC_IN_MOD_ADR) | is_cmd(io_func, FC_IN_RANGE)
                 | is_cmd(io_func, FC_IN_FORMAT) | is_cmd(io_func, FC_IN_DEV_ID);
  wire ascii_md  = (format_q == FORMAT_RST);
  wire active    = (state_q == CRD_READ);

  // status word
  wire [15:0] status_w = {ready_s2_q, attn_q, dsr_q, dev_switches, rdchk_q, ascerr_q,
                          3'b000, 1'b0, nxr_q, par_q, 1'b0}; // R20

  // read data selection
  wire [15:0] rd_sel =
      (io_func == FC_IN_INT_CTL)  ? int_target_q :       // R15
      (io_func == FC_IN_BYTE_ADR) ? addr_q[15:0] :       // R16
      (io_func == FC_IN_MOD_ADR)  ? {8'h00, addr_q[23:16]} : // R17
      (io_func == FC_IN_RANGE)    ? range_q :            // R18
      (io_func == FC_IN_FORMAT)   ? format_q :           // R19
      (io_func == FC_IN_STATUS)   ? status_w :           // R20
      (io_func == FC_IN_DEV_ID)   ? DEVICE_IDENTIFIER : 16'h0000; // R21

  // column to byte / word
  wire [7:0]  col_byte = (col_in.ascii_ok) ? col_in.ascii : ASCII_ERR_BYTE; // R24
  wire        col_take = col_valid && active;
  wire        fifo_in_ready;
  logic       fifo_push;
  logic [17:0] fifo_word;
  wire        range_last = (remain_q == 16'h0001);
  wire        xfer_end   = col_take && (col_in.last || range_last); // R12

  always_comb begin
    fifo_push = 1'b0;
    fifo_word = '0;
    if (col_take) begin
      if (!ascii_md) begin
        fifo_push = 1'b1;
        fifo_word = {2'b11, 4'h0, col_in.holes}; // R25
      end else if (have_hi_q) begin
        fifo_push = 1'b1;
        fifo_word = {2'b11, hi_byte_q, col_byte}; // R1
      end else if (xfer_end) begin
        fifo_push = 1'b1;
        fifo_word = {2'b10, col_byte, 8'h00}; // R1
      end
    end
  end

  wire fifo_out_valid;
  wire [17:0] fifo_out;
  wire fifo_empty;
  crd_fifo #(.WIDTH(18), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .srst      (srst || ctl_init || ctl_stop),
    .in_data   (fifo_word),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (mem_ready),
    .empty     (fifo_empty)
  );
  assign mem_valid      = fifo_out_valid;
  assign mem_wr.addr    = wr_addr_q;
  assign mem_wr.data    = fifo_out[15:0];
  assign mem_wr.byte_en = fifo_out[17:16];
  wire   mem_pop        = fifo_out_valid && mem_ready;
  wire   [23:0] ascii_step = fifo_out[16] ? 24'h00_0002 : 24'h00_0001;

  // bus answers: control never refused
  assign io_ack  = known_cmd;                        // R5
  assign io_wait = 1'b0;
  assign busy    = (state_q != CRD_IDLE);
  assign self_test = test_q;
  assign int_req  = int_pend_q;
  assign int_addr = int_target_q[15:6]; // R4
  assign int_data = int_target_q[5:0];  // R4

  // registers loaded by output commands, read data latched on every command
  always_ff @(posedge clk) begin
    if (srst) begin
      int_target_q <= INT_TARGET_RST;
      format_q     <= FORMAT_RST;
      range_q      <= RANGE_RST;
      hold_q       <= 1'b0;
      test_q       <= 1'b0;
      io_rdata     <= 16'h0000;
    end else begin
      if (io_cmd_valid) io_rdata <= rd_sel;
      if (cmd_int) int_target_q <= io_wdata[15:0]; // R3
      if (cmd_rng) range_q <= io_wdata[15:0];
      if (ctl_init) format_q <= FORMAT_RST; // R6
      else if (cmd_fmt) format_q <= io_wdata[15:0]; // R14
      if (cmd_ctl) begin
        hold_q <= io_wdata[CTL_HOLD]; // R8
        test_q <= io_wdata[CTL_INIT] | io_wdata[CTL_TEST]; // R6
      end else test_q <= 1'b0;
    end
  end

  // transfer sequencing
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q   <= CRD_IDLE;
      remain_q  <= RANGE_RST;
      have_hi_q <= 1'b0;
      hi_byte_q <= 8'h00;
    end else if (ctl_init || ctl_stop) begin
      state_q   <= CRD_IDLE; // R6 R7
      have_hi_q <= 1'b0;
    end else begin
      case (state_q)
        CRD_IDLE: if (cmd_rng) begin
          state_q   <= CRD_READ; // R13
          remain_q  <= io_wdata[15:0];
          have_hi_q <= 1'b0;
        end
        CRD_READ: if (col_take) begin
          remain_q  <= remain_q - 16'h0001;
          if (ascii_md) begin
            have_hi_q <= !have_hi_q;
            hi_byte_q <= col_byte;
          end
          if (xfer_end) state_q <= CRD_DRAIN; // R12
        end
        CRD_DRAIN: if (fifo_empty) state_q <= CRD_IDLE; // R26
        default: state_q <= CRD_IDLE;
      endcase
    end
  end

  // dma address
  always_ff @(posedge clk) begin
    if (srst) begin
      addr_q    <= ADDR_RST;
      wr_addr_q <= ADDR_RST;
    end else if (cmd_adr) begin
      addr_q    <= io_wdata; // R10
      wr_addr_q <= io_wdata;
    end else if (mem_pop && !hold_q) begin // R8
      wr_addr_q <= wr_addr_q + (ascii_md ? ascii_step : 24'd2);
      addr_q    <= wr_addr_q + (ascii_md ? ascii_step : 24'd2);
    end
  end

  // interrupt and status flags
  wire done_evt = (state_q == CRD_DRAIN && fifo_empty) || (ctl_stop && busy);
  always_ff @(posedge clk) begin
    if (srst) begin
      int_block_q  <= 1'b1;
      int_pend_q   <= 1'b0;
      ready_s1_q   <= 1'b0;
      ready_s2_q   <= 1'b0;
      ready_prev_q <= 1'b0;
      attn_q       <= 1'b0;
      {dsr_q, rdchk_q, ascerr_q, nxr_q, par_q} <= '0;
    end else begin
      ready_s1_q   <= dev_ready;
      ready_s2_q   <= ready_s1_q;
      ready_prev_q <= ready_s2_q;
      if (ctl_init) int_block_q <= 1'b1; // R6
      else if (cmd_int) int_block_q <= 1'b0;
      if (ctl_init) int_pend_q <= 1'b0;
      else if (done_evt && !int_block_q) int_pend_q <= 1'b1; // R26 R7
      else if (int_taken) int_pend_q <= 1'b0;
      if (ready_s2_q != ready_prev_q) attn_q <= 1'b1; // R22
      else if (cmd_stat) attn_q <= 1'b0;
      if (col_take && !fifo_in_ready && fifo_push) dsr_q <= 1'b1; // R23
      else if (cmd_adr) dsr_q <= 1'b0;
      if (col_take && ascii_md && !col_in.ascii_ok) ascerr_q <= 1'b1; // R24
      else if (cmd_adr) ascerr_q <= 1'b0;
      if (dev_read_check) rdchk_q <= 1'b1;
      else if (cmd_adr) rdchk_q <= 1'b0;
      if (mem_nak) nxr_q <= 1'b1;
      else if (cmd_adr) nxr_q <= 1'b0;
      if (bus_parity_err) par_q <= 1'b1;
      else if (cmd_adr) par_q <= 1'b0;
    end
  end

  // checks
  sequence s_range_idle;
    cmd_rng && !busy;
  endsequence
  sequence s_done_open;
    done_evt && !int_block_q && !ctl_init;
  endsequence
  sequence s_int_release;
    int_req && int_taken && !done_evt;
  endsequence

  a_stat_attn_clr: assert property ( // R22
    cmd_stat && ready_s2_q == ready_prev_q |=> !attn_q)
    else $error("attention not cleared");
  a_attn_set: assert property ( // R22
    ready_s2_q != ready_prev_q |=> attn_q)
    else $error("attention not set");
  a_range_start: assert property ( // R13
    s_range_idle |=> busy && remain_q == $past(io_wdata[15:0]))
    else $error("range did not start");
  a_stop_idle: assert property ( // R7
    ctl_stop |=> !busy)
    else $error("stop left busy");
  a_stop_flush: assert property ( // R7
    ctl_stop |=> !mem_valid)
    else $error("stop left writes queued");
  a_init_ascii: assert property ( // R6
    ctl_init |=> format_q == FORMAT_RST && int_block_q && !int_req)
    else $error("init wrong");
  a_blocked_quiet: assert property ( // R6
    int_block_q && !int_req |=> !int_req)
    else $error("interrupt while blocked");
  a_ctl_ack: assert property ( // R5
    cmd_ctl |-> io_ack && !io_wait)
    else $error("control refused");
  a_bin_pack: assert property ( // R25
    fifo_push && !ascii_md |-> fifo_word[15:12] == 4'h0)
    else $error("binary upper bits");
  a_pair_left: assert property ( // R1
    col_take && ascii_md && !have_hi_q && !ctl_init && !ctl_stop |=> have_hi_q && hi_byte_q == $past(col_byte))
    else $error("first column not in left byte");
  a_hold_addr: assert property ( // R8
    hold_q && !cmd_adr |=> $stable(wr_addr_q))
    else $error("address moved under hold");
  a_adr_load: assert property ( // R10
    cmd_adr |=> wr_addr_q == $past(io_wdata) && addr_q == $past(io_wdata))
    else $error("start address not loaded");
  a_int_load: assert property ( // R3
    cmd_int |=> int_target_q == $past(io_wdata[15:0]))
    else $error("interrupt control not loaded");
  a_fmt_load: assert property ( // R14
    cmd_fmt |=> format_q == $past(io_wdata[15:0]))
    else $error("configuration not loaded");
  a_int_read: assert property ( // R15
    is_cmd(io_func, FC_IN_INT_CTL) |=> io_rdata == $past(int_target_q))
    else $error("interrupt control read");
  a_byte_adr_read: assert property ( // R16
    is_cmd(io_func, FC_IN_BYTE_ADR) |=> io_rdata == $past(addr_q[15:0]))
    else $error("byte address read");
  a_mod_adr_read: assert property ( // R17
    is_cmd(io_func, FC_IN_MOD_ADR) |=> io_rdata == {8'h00, $past(addr_q[23:16])})
    else $error("module address read");
  a_range_read: assert property ( // R18
    is_cmd(io_func, FC_IN_RANGE) |=> io_rdata == $past(range_q))
    else $error("range read");
  a_fmt_read: assert property ( // R19
    is_cmd(io_func, FC_IN_FORMAT) |=> io_rdata == $past(format_q))
    else $error("configuration read");
  a_status_read: assert property ( // R20
    cmd_stat |=> io_rdata[ST_READY] == $past(ready_s2_q))
    else $error("status ready bit");
  a_dev_id: assert property ( // R21
    is_cmd(io_func, FC_IN_DEV_ID) |=> io_rdata == DEVICE_IDENTIFIER)
    else $error("id wrong");
  a_ascii_err: assert property ( // R24
    col_take && ascii_md && !col_in.ascii_ok |=> ascerr_q)
    else $error("ascii error not flagged");
  a_dsr_set: assert property ( // R23
    fifo_push && !fifo_in_ready |=> dsr_q)
    else $error("lost data not flagged");
  a_dsr_clr: assert property ( // R23
    cmd_adr && !(fifo_push && !fifo_in_ready) |=> !dsr_q)
    else $error("service error not cleared");
  a_end_drain: assert property ( // R12
    xfer_end && !ctl_init && !ctl_stop |=> state_q == CRD_DRAIN)
    else $error("transfer did not end");
  a_done_int: assert property ( // R26
    s_done_open |=> int_req)
    else $error("end of transfer without interrupt");
  a_int_release: assert property ( // R26
    s_int_release |=> !int_req)
    else $error("interrupt held after taken");
  a_int_vector: assert property ( // R4
    int_req |-> int_addr == int_target_q[15:6] && int_data == int_target_q[5:0])
    else $error("vector");
endmodule : crd_channel
`default_nettype wire

// *** bench/crd_host_model.sv ***
// host and memory model: takes dma writes, acknowledges interrupts
// assumes the channel's write and interrupt ports on the same clock
`timescale 1ns/10ps
`default_nettype none
module crd_host_model
  import crd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        stall,
  input  wire logic        slow,
  input  wire logic        mem_valid,
  input  wire crd_mem_wr_s mem_wr,
  output logic             mem_ready,
  input  wire logic        int_req,
  input  wire logic [9:0]  int_addr,
  input  wire logic [5:0]  int_data,
  output logic             int_taken
);
  crd_mem_wr_s wr_log [0:63];
  int          wcount;
  int          icount;
  logic [9:0]  got_addr;
  logic [5:0]  got_level;
  logic        tick_q;
  logic [1:0]  wait_q;
  // slow mode offers ready every other cycle, stall withholds it
  assign mem_ready = !stall && (!slow || tick_q);
  always_ff @(posedge clk) begin
    if (srst) begin
      wcount    <= 0;
      icount    <= 0;
      tick_q    <= 1'b0;
      wait_q    <= 2'h0;
      int_taken <= 1'b0;
    end else begin
      tick_q    <= !tick_q;
      int_taken <= 1'b0;
      if (mem_valid && mem_ready) begin
        wr_log[wcount[5:0]] <= mem_wr;
        wcount              <= wcount + 1;
      end
      if (!int_req || int_taken) begin
        wait_q <= 2'h0;
      end else if (wait_q == 2'h2) begin
        int_taken <= 1'b1;
        got_addr  <= int_addr;
        got_level <= int_data;
        icount    <= icount + 1;
      end else begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule : crd_host_model
`default_nettype wire

// *** bench/tb.sv ***
// self-checking bench for the card reader dma channel
// assumes crd_channel and crd_host_model on one 200 MHz clock
`timescale 1ns/10ps
`default_nettype none
module tb;
  import crd_pkg::*;
  logic        clk, srst, io_cmd_valid, io_ack, io_wait, col_valid, dev_ready;
  logic        dev_read_check, bus_parity_err, mem_nak, mem_valid, mem_ready;
  logic        int_req, int_taken, busy, self_test, stall, slow;
  logic [5:0]  io_func;
  logic [23:0] io_wdata;
  logic [15:0] io_rdata;
  logic [3:0]  dev_switches;
  logic [9:0]  int_addr;
  logic [5:0]  int_data;
  crd_column_s col_in;
  crd_mem_wr_s mem_wr;
  int          fails, check_count, base;
  localparam logic [15:0] TB_DEV_ID = 16'h0ABC; // arbitrary identifier value

  crd_channel #(.DEVICE_IDENTIFIER(TB_DEV_ID))
    crd_channel_i (.clk(clk), .srst(srst), .io_cmd_valid(io_cmd_valid), .io_func(io_func),
    .io_wdata(io_wdata), .io_ack(io_ack), .io_wait(io_wait), .io_rdata(io_rdata), .col_valid(col_valid),
    .col_in(col_in), .dev_ready(dev_ready), .dev_switches(dev_switches), .dev_read_check(dev_read_check),
    .bus_parity_err(bus_parity_err), .mem_nak(mem_nak), .mem_valid(mem_valid), .mem_wr(mem_wr),
    .mem_ready(mem_ready), .int_req(int_req), .int_addr(int_addr), .int_data(int_data),
    .int_taken(int_taken), .busy(busy), .self_test(self_test));
  crd_host_model mem_i (.clk(clk), .srst(srst), .stall(stall), .slow(slow), .mem_valid(mem_valid),
    .mem_wr(mem_wr), .mem_ready(mem_ready), .int_req(int_req), .int_addr(int_addr),
    .int_data(int_data), .int_taken(int_taken));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input logic [5:0] f, input logic [23:0] d, input logic ack_exp);
    @(posedge clk);
    io_cmd_valid <= 1'b1;
    io_func      <= f;
    io_wdata     <= d;
    #1;
    chk({io_wait, io_ack}, {1'b0, ack_exp});
    @(posedge clk);
    io_cmd_valid <= 1'b0;
    #1;
  endtask : cmd
  task automatic rd(input logic [5:0] f, input logic [15:0] exp, input logic [15:0] m);
    cmd(f, 24'h00_0000, 1'b1);
    chk(io_rdata & m, exp);
  endtask : rd
  task automatic col(input logic [11:0] h, input logic [7:0] a, input logic ok, input logic last);
    @(posedge clk);
    col_valid <= 1'b1;
    col_in    <= {h, a, ok, last};
    @(posedge clk);
    col_valid <= 1'b0;
  endtask : col
  task automatic start(input logic [15:0] fmt, input logic [23:0] a, input logic [15:0] r);
    cmd(FC_OUT_FORMAT, {8'h00, fmt}, 1'b1);
    base = mem_i.wcount;
    cmd(FC_OUT_ADDRESS, a, 1'b1);
    cmd(FC_OUT_RANGE, {8'h00, r}, 1'b1);
    @(posedge clk);
    #1;
    chk(busy, 1'b1);
  endtask : start
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 || mem_valid !== 1'b0) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 3000) begin
        fails++;
        tally_and_finish();
      end
    end
  endtask : wait_idle
  task automatic wait_int(input int n0);
    int n;
    for (n = 0; n < 60 && mem_i.icount == n0; n++) @(posedge clk);
    #1;
    chk(mem_i.icount, n0 + 1);
    chk({mem_i.got_addr, mem_i.got_level}, {10'h2A5, 6'h15});
    if (mem_i.icount == n0) tally_and_finish();
  endtask : wait_int
  task automatic wchk(input int k, input logic [23:0] a, input logic [15:0] d, input logic [1:0] be);
    crd_mem_wr_s e;
    int          i;
    i = base + k;
    e = mem_i.wr_log[i[5:0]];
    chk(e.addr, a);
    chk({e.data & ((be == 2'b10) ? 16'hFF00 : 16'hFFFF), e.byte_en}, {d, be});
  endtask : wchk

  task automatic t_regs();
    rd(FC_IN_INT_CTL, INT_TARGET_RST, 16'hFFFF);
    rd(FC_IN_RANGE, RANGE_RST, 16'hFFFF);
    rd(FC_IN_FORMAT, FORMAT_RST, 16'hFFFF);
    rd(FC_IN_DEV_ID, TB_DEV_ID, 16'hFFFF);
    cmd(6'h3F, 24'h00_0000, 1'b0);
    cmd(FC_OUT_INT_CTL, 24'h00_A955, 1'b1);
    rd(FC_IN_INT_CTL, 16'hA955, 16'hFFFF);
    cmd(FC_OUT_ADDRESS, 24'h12_3456, 1'b1);
    rd(FC_IN_BYTE_ADR, 16'h3456, 16'hFFFF);
    rd(FC_IN_MOD_ADR, 16'h0012, 16'hFFFF);
    cmd(FC_OUT_FORMAT, {8'h00, FMT_BINARY}, 1'b1);
    rd(FC_IN_FORMAT, FMT_BINARY, 16'hFFFF);
    $display("test regs done");
  endtask : t_regs
  task automatic t_ascii();
    int ic;
    ic   = mem_i.icount;
    slow <= 1'b1;
    start(16'h0000, 24'h00_1000, 16'h0003);
    rd(FC_IN_RANGE, 16'h0003, 16'hFFFF);
    col(12'h000, 8'h41, 1'b1, 1'b0);
    col(12'h000, 8'h42, 1'b1, 1'b0);
    col(12'hFFF, 8'h43, 1'b0, 1'b0);
    wait_idle();
    wait_int(ic);
    chk(mem_i.wcount - base, 2);
    wchk(0, 24'h00_1000, 16'h4142, 2'b11);
    wchk(1, 24'h00_1002, {ASCII_ERR_BYTE, 8'h00}, 2'b10);
    rd(FC_IN_BYTE_ADR, 16'h1003, 16'hFFFF);
    rd(FC_IN_STATUS, 16'h0080, 16'h0080);
    slow <= 1'b0;
    $display("test ascii done");
  endtask : t_ascii
  task automatic t_bin_hold();
    start(FMT_BINARY, 24'h00_2000, 16'h000A);
    col(12'hABC, 8'h00, 1'b1, 1'b0);
    col(12'h123, 8'h00, 1'b1, 1'b1);
    wait_idle();
    chk(mem_i.wcount - base, 2);
    wchk(0, 24'h00_2000, 16'h0ABC, 2'b11);
    wchk(1, 24'h00_2002, 16'h0123, 2'b11);
    rd(FC_IN_STATUS, 16'h0000, 16'h0080);
    cmd(FC_OUT_CONTROL, 24'h00_1000, 1'b1);
    start(FMT_BINARY, 24'h00_3000, 16'h000A);
    for (int i = 0; i < 3; i++) col(12'h00F, 8'h00, 1'b1, i == 2);
    wait_idle();
    for (int i = 0; i < 3; i++) wchk(i, 24'h00_3000, 16'h000F, 2'b11);
    cmd(FC_OUT_CONTROL, 24'h00_0000, 1'b1);
    $display("test binary and hold done");
  endtask : t_bin_hold
  task automatic t_stop_init();
    int ic;
    repeat (8) @(posedge clk);
    ic = mem_i.icount;
    start(FMT_BINARY, 24'h00_4000, 16'h000A);
    col(12'h555, 8'h00, 1'b1, 1'b0);
    cmd(FC_OUT_CONTROL, 24'h00_4000, 1'b1);
    wait_idle();
    wait_int(ic);
    ic = mem_i.icount;
    cmd(FC_OUT_CONTROL, 24'h00_8000, 1'b1);
    for (int n = 0; n < 4 && self_test !== 1'b1; n++) @(posedge clk);
    chk(self_test, 1'b1);
    rd(FC_IN_FORMAT, 16'h0000, 16'h0001);
    start(16'h0000, 24'h00_6000, 16'h0002);
    col(12'h000, 8'h31, 1'b1, 1'b0);
    col(12'h000, 8'h32, 1'b1, 1'b1);
    wait_idle();
    repeat (20) @(posedge clk);
    chk(mem_i.icount, ic);
    cmd(FC_OUT_INT_CTL, 24'h00_A955, 1'b1);
    $display("test stop and init done");
  endtask : t_stop_init
  task automatic t_status();
    stall <= 1'b1;
    start(FMT_BINARY, 24'h00_5000, 16'h0100);
    for (int i = 0; i < 40; i++) col(i[11:0], 8'h00, 1'b1, i == 39);
    rd(FC_IN_STATUS, 16'h2000, 16'h2000);
    @(posedge clk);
    dev_ready      <= 1'b1;
    dev_switches   <= 4'hF;
    dev_read_check <= 1'b1;
    bus_parity_err <= 1'b1;
    mem_nak        <= 1'b1;
    @(posedge clk);
    dev_read_check <= 1'b0;
    bus_parity_err <= 1'b0;
    mem_nak        <= 1'b0;
    repeat (4) @(posedge clk);
    rd(FC_IN_STATUS, 16'hFF06, 16'hFF06);
    rd(FC_IN_STATUS, 16'h0000, 16'h4000);
    stall <= 1'b0;
    wait_idle();
    chk(mem_i.wcount - base, 32);
    cmd(FC_OUT_ADDRESS, 24'h00_7000, 1'b1);
    rd(FC_IN_STATUS, 16'h8000, 16'hA106);
    $display("test status and buffer done");
  endtask : t_status

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    {srst, io_cmd_valid, col_valid, stall, slow} = 5'b10000;
    {dev_ready, dev_read_check, bus_parity_err, mem_nak} = 4'h0;
    io_func      = 6'h00;
    io_wdata     = 24'h00_0000;
    col_in       = '0;
    dev_switches = 4'h0;
    fails        = 0;
    check_count  = 0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_ascii();
    t_bin_hold();
    t_stop_init();
    t_status();
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
